// *** logic/mcdm_delay_manager.v ***
// Commutation delay manager: step timer, captures, compares, multiplier, AHB-Lite slave
// Notes on behaviour
// - Autoswitch bit selects switched or autoswitched commutation.
// - Compare is read-only when autoswitched.
// - Switched: timer equals compare gives commutation, clear.
// - Commutation loads preloads, sets flag, may interrupt.
// - Switched timer overflow raises ratio-increment interrupt.
// - Step ratio writable only while clock disabled.
// - Switched: software ratio flags adjust prescaler at commutation.
// - One prescaler update per step, increment first.
// - Switched: events never change timer.
// - Autoswitched commutation leaves timer unchanged.
// - Zero-crossing captures timer, shifts capture, resets timer.
// - Compare equals weight times selected capture over 32.
// - Multiply overflow loads ffh, overflow interrupt.
// - Autoswitched timer at ffh: increment ratio, shift right.
// - Zero-crossing below 55h: decrement ratio, shift left.
// - Ratio zero: skip decrement, no interrupt.
// - Ratio fifteen at ffh: freeze timer at ffh.
// - Five timer registers reset to 00h.
// - Preloads move at commutation or phase write.
// - Timer and capture registers writable until clock enabled.
// - Reset, autoswitch, enable bits set register access.
//
// The AHB-Lite slave port and the address map were left to the implementer.
`timescale 1ns/1ps
`include "mcdm_map.vh"
module mcdm_delay_manager #(
	parameter PRESC_W = 16
) (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// AHB-Lite slave
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [2:0] hsize,
	input wire [31:0] hwdata,
	input wire hready,
	output wire hreadyout,
	output wire hresp,
	output reg [31:0] hrdata,
	// Rotor position events, async pins
	input wire zero_cross_evt,
	input wire demag_evt,
	// Outputs to channel manager
	output reg commutation_pulse,
	output reg demag_match_pulse,
	output wire [3:0] active_ctrl_b,
	output wire [7:0] active_phase,
	output wire event_irq
);
	// ----------------------------------------
	// Registers
	// ----------------------------------------
	reg [7:0] step_timer_value_r;
	reg [7:0] previous_zero_cross_capture_r;
	reg [7:0] latest_zero_cross_capture_r;
	reg [7:0] commutation_compare_r;
	reg [7:0] demagnetization_compare_r;
	reg [7:0] phase_weight_r;
	reg [3:0] event_flag_register_r;
	reg [3:0] event_mask_register_r;
	reg [4:0] control_register_a_r;
	reg [3:0] ctrl_b_pre_r;
	reg [3:0] ctrl_b_act_r;
	reg [7:0] phase_pre_r;
	reg [7:0] phase_act_r;
	reg [3:0] step_ratio_r;
	reg [PRESC_W-1:0] presc_cnt_r;
	reg pend_dec_r;
	reg stalled_r;
	reg recalc_r;
	reg [1:0] z_sync_r;
	reg [1:0] d_sync_r;
	reg z_prev_r;
	reg d_prev_r;
	reg a_valid_r;
	reg a_write_r;
	reg [7:0] a_addr_r;
	// ----------------------------------------
	// Mode decode
	// ----------------------------------------
	wire oe = control_register_a_r[`MCDM_CA_OE];
	wire auto_sel = control_register_a_r[`MCDM_CA_AUTO];
	wire cap_sel = control_register_a_r[`MCDM_CA_CSEL];
	wire soft_rst = control_register_a_r[`MCDM_CA_RST];
	wire direct = control_register_a_r[`MCDM_CA_DIRECT];
	// clock enabled only with output enable out of reset
	wire running = oe & ~soft_rst;
	wire switched = running & ~auto_sel;
	wire autosw = running & auto_sel;
	// timer registers writable in config and emergency stop
	wire tregs_wr = ~running;
	// ----------------------------------------
	// Event synchronisers
	// ----------------------------------------
	wire z_lvl = z_sync_r[1];
	wire d_lvl = d_sync_r[1];
	wire z_evt = z_lvl & ~z_prev_r;
	wire d_evt = d_lvl & ~d_prev_r;
	always @(posedge clk_sys) begin
		if (rst) begin
			z_sync_r <= 2'h0;
			d_sync_r <= 2'h0;
			z_prev_r <= 1'b0;
			d_prev_r <= 1'b0;
		end else begin
			z_sync_r <= {z_sync_r[0], zero_cross_evt};
			d_sync_r <= {d_sync_r[0], demag_evt};
			z_prev_r <= z_lvl;
			d_prev_r <= d_lvl;
		end
	end
	// ----------------------------------------
	// AHB-Lite address phase
	// ----------------------------------------
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	wire take = hsel & hready & htrans[1];
	always @(posedge clk_sys) begin
		if (rst) begin
			a_valid_r <= 1'b0;
			a_write_r <= 1'b0;
			a_addr_r <= 8'h00;
		end else begin
			a_valid_r <= take;
			a_write_r <= hwrite;
			a_addr_r <= haddr[7:0];
		end
	end
	wire wr = a_valid_r & a_write_r;
	wire [7:0] wd = hwdata[7:0];
	wire wr_timer = wr & (a_addr_r == `MCDM_OFF_TIMER) & tregs_wr;
	wire wr_zprev = wr & (a_addr_r == `MCDM_OFF_ZPREV) & tregs_wr;
	wire wr_zlast = wr & (a_addr_r == `MCDM_OFF_ZLAST) & tregs_wr;
	wire wr_comp = wr & (a_addr_r == `MCDM_OFF_COMP) & ~autosw;
	wire wr_demag = wr & (a_addr_r == `MCDM_OFF_DEMAG);
	wire wr_presc = wr & (a_addr_r == `MCDM_OFF_PRESC) & tregs_wr;
	wire wr_flags = wr & (a_addr_r == `MCDM_OFF_FLAGS);
	wire wr_phase = wr & (a_addr_r == `MCDM_OFF_PHASE);
	// ----------------------------------------
	// Prescaler tick
	// ----------------------------------------
	wire [PRESC_W-1:0] presc_lim = ({{(PRESC_W-1){1'b0}}, 1'b1} << step_ratio_r) - 1'b1;
	wire tick = running & ~stalled_r & (presc_cnt_r >= presc_lim);
	// ----------------------------------------
	// Multiplier
	// ----------------------------------------
	// selected capture times weight over 32
	wire [7:0] mul_src = cap_sel ? latest_zero_cross_capture_r : previous_zero_cross_capture_r;
	wire [15:0] product = mul_src * phase_weight_r;
	wire [10:0] quot = product[15:`MCDM_MUL_SHIFT];
	wire mul_ovf = |quot[10:8];
	wire [7:0] mul_res = mul_ovf ? `MCDM_TIMER_MAX : quot[7:0];
	// ----------------------------------------
	// Step events
	// ----------------------------------------
	// switched commutation on match
	wire sw_comm = switched & tick & (step_timer_value_r == commutation_compare_r);
	wire au_comm = autosw & tick & (step_timer_value_r == commutation_compare_r);
	wire comm = sw_comm | au_comm;
	wire at_max = step_timer_value_r == `MCDM_TIMER_MAX;
	wire sw_ovf = switched & tick & at_max & ~sw_comm;
	wire au_ovf = autosw & tick & at_max;
	wire au_inc = au_ovf & (step_ratio_r != `MCDM_RATIO_MAX);
	wire au_stall = au_ovf & (step_ratio_r == `MCDM_RATIO_MAX);
	wire au_z = autosw & z_evt;
	wire au_dec = au_z & (step_timer_value_r < `MCDM_TIMER_LOW) &
		(step_ratio_r != `MCDM_RATIO_MIN);
	// software ratio change at commutation, increment first
	wire sw_inc = sw_comm & event_flag_register_r[`MCDM_F_RINC];
	wire sw_dec = sw_comm & ~event_flag_register_r[`MCDM_F_RINC] &
		(event_flag_register_r[`MCDM_F_RDEC] | pend_dec_r) & (step_ratio_r != `MCDM_RATIO_MIN);
	wire do_inc = au_inc | (sw_inc & (step_ratio_r != `MCDM_RATIO_MAX));
	wire do_dec = au_dec | sw_dec;
	// ----------------------------------------
	// Timer datapath
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (rst) begin
			step_timer_value_r <= `MCDM_RST_8;
			previous_zero_cross_capture_r <= `MCDM_RST_8;
			latest_zero_cross_capture_r <= `MCDM_RST_8;
			commutation_compare_r <= `MCDM_RST_8;
			demagnetization_compare_r <= `MCDM_RST_8;
			step_ratio_r <= `MCDM_RST_4;
			presc_cnt_r <= {PRESC_W{1'b0}};
			stalled_r <= 1'b0;
			pend_dec_r <= 1'b0;
			recalc_r <= 1'b0;
		end else begin
			presc_cnt_r <= (tick | ~running) ? {PRESC_W{1'b0}} : presc_cnt_r + 1'b1;
			recalc_r <= au_z | do_inc | do_dec;
			if (~autosw)
				stalled_r <= 1'b0;
			else if (au_stall)
				stalled_r <= 1'b1;
			else if (au_z)
				stalled_r <= 1'b0;
			if (sw_comm & event_flag_register_r[`MCDM_F_RINC] &
				event_flag_register_r[`MCDM_F_RDEC])
				pend_dec_r <= 1'b1;
			else if (sw_dec | ~switched)
				pend_dec_r <= 1'b0;
			if (wr_presc)
				step_ratio_r <= wd[3:0];
			else if (do_inc)
				step_ratio_r <= step_ratio_r + 4'h1;
			else if (do_dec)
				step_ratio_r <= step_ratio_r - 4'h1;
			if (do_inc) begin
				step_timer_value_r <= au_inc ? 8'h80 : 8'h00;
				previous_zero_cross_capture_r <= {1'b0, previous_zero_cross_capture_r[7:1]};
				latest_zero_cross_capture_r <= {1'b0, latest_zero_cross_capture_r[7:1]};
				commutation_compare_r <= {1'b0, commutation_compare_r[7:1]};
				demagnetization_compare_r <= {1'b0, demagnetization_compare_r[7:1]};
			end else if (do_dec) begin
				previous_zero_cross_capture_r <= au_dec ? latest_zero_cross_capture_r << 1 :
					previous_zero_cross_capture_r << 1;
				latest_zero_cross_capture_r <= au_dec ? step_timer_value_r << 1 :
					latest_zero_cross_capture_r << 1;
				step_timer_value_r <= 8'h00;
				commutation_compare_r <= au_dec ? mul_res : commutation_compare_r << 1;
				demagnetization_compare_r <= demagnetization_compare_r << 1;
			end else begin
				if (wr_timer)
					step_timer_value_r <= wd;
				// capture and reset on zero crossing
				else if (au_z)
					step_timer_value_r <= 8'h00;
				else if (sw_comm)
					step_timer_value_r <= 8'h00;
				else if (tick & ~au_stall)
					step_timer_value_r <= step_timer_value_r + 8'h01;
				if (wr_zprev)
					previous_zero_cross_capture_r <= wd;
				else if (au_z)
					previous_zero_cross_capture_r <= latest_zero_cross_capture_r;
				if (wr_zlast)
					latest_zero_cross_capture_r <= wd;
				else if (au_z)
					latest_zero_cross_capture_r <= step_timer_value_r;
				if (wr_comp)
					commutation_compare_r <= wd;
				else if (autosw)
					commutation_compare_r <= mul_res;
				if (wr_demag)
					demagnetization_compare_r <= wd;
			end
		end
	end
	// ----------------------------------------
	// Flags, masks, control
	// ----------------------------------------
	wire [3:0] set_v;
	assign set_v[`MCDM_F_COMM] = comm;
	assign set_v[`MCDM_F_RINC] = au_inc | sw_ovf;
	assign set_v[`MCDM_F_RDEC] = au_dec;
	// overflow of the product computed after a capture or shift
	assign set_v[`MCDM_F_OI] = autosw & mul_ovf & recalc_r;
	wire [3:0] used_v = {1'b0, sw_dec & event_flag_register_r[`MCDM_F_RDEC], sw_inc, 1'b0};
	always @(posedge clk_sys) begin
		if (rst) begin
			event_flag_register_r <= `MCDM_RST_4;
			event_mask_register_r <= `MCDM_RST_4;
			control_register_a_r <= 5'h00;
			phase_weight_r <= `MCDM_RST_8;
			ctrl_b_pre_r <= `MCDM_RST_4;
			ctrl_b_act_r <= `MCDM_RST_4;
			phase_pre_r <= `MCDM_RST_8;
			phase_act_r <= `MCDM_RST_8;
			commutation_pulse <= 1'b0;
			demag_match_pulse <= 1'b0;
		end else begin
			// software sets ratio flags when switched, clears otherwise; set wins
			if (wr_flags)
				event_flag_register_r <= set_v | (switched ?
					(wd[3:0] | (event_flag_register_r & ~used_v)) :
					(event_flag_register_r & wd[3:0]));
			else
				event_flag_register_r <= set_v | (event_flag_register_r & ~used_v);
			if (wr & (a_addr_r == `MCDM_OFF_MASK))
				event_mask_register_r <= wd[3:0];
			if (wr & (a_addr_r == `MCDM_OFF_CTRLA))
				control_register_a_r <= wd[4:0];
			if (wr & (a_addr_r == `MCDM_OFF_WEIGHT))
				phase_weight_r <= wd;
			if (wr & (a_addr_r == `MCDM_OFF_CTRLB))
				ctrl_b_pre_r <= wd[3:0];
			if (wr_phase)
				phase_pre_r <= wd;
			if ((comm & ~direct) | (wr_phase & direct)) begin
				ctrl_b_act_r <= (wr & (a_addr_r == `MCDM_OFF_CTRLB)) ? wd[3:0] : ctrl_b_pre_r;
				phase_act_r <= wr_phase ? wd : phase_pre_r;
			end
			commutation_pulse <= comm;
			demag_match_pulse <= running & tick &
				(step_timer_value_r == demagnetization_compare_r) | (running & d_evt);
		end
	end
	assign active_ctrl_b = ctrl_b_act_r;
	assign active_phase = phase_act_r;
	assign event_irq = |(event_flag_register_r & event_mask_register_r);
	// ----------------------------------------
	// Read data
	// ----------------------------------------
	always @* begin
		case (a_addr_r)
			`MCDM_OFF_TIMER: hrdata = {24'h000000, step_timer_value_r};
			`MCDM_OFF_ZPREV: hrdata = {24'h000000, previous_zero_cross_capture_r};
			`MCDM_OFF_ZLAST: hrdata = {24'h000000, latest_zero_cross_capture_r};
			`MCDM_OFF_COMP: hrdata = {24'h000000, commutation_compare_r};
			`MCDM_OFF_DEMAG: hrdata = {24'h000000, demagnetization_compare_r};
			`MCDM_OFF_WEIGHT: hrdata = {24'h000000, phase_weight_r};
			`MCDM_OFF_FLAGS: hrdata = {28'h0000000, event_flag_register_r};
			`MCDM_OFF_MASK: hrdata = {28'h0000000, event_mask_register_r};
			`MCDM_OFF_CTRLA: hrdata = {27'h0000000, control_register_a_r};
			`MCDM_OFF_CTRLB: hrdata = {28'h0000000, ctrl_b_pre_r};
			`MCDM_OFF_PRESC: hrdata = {27'h0000000, stalled_r, step_ratio_r};
			`MCDM_OFF_PHASE: hrdata = {24'h000000, phase_pre_r};
			default: hrdata = 32'h00000000;
		endcase
	end
endmodule

// *** include/mcdm_map.vh ***
// Register offsets, field positions, reset values and thresholds for the delay manager
`ifndef MCDM_MAP_VH
`define MCDM_MAP_VH
// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define MCDM_OFF_TIMER 8'h00
`define MCDM_OFF_ZPREV 8'h04
`define MCDM_OFF_ZLAST 8'h08
`define MCDM_OFF_COMP 8'h0c
`define MCDM_OFF_DEMAG 8'h10
`define MCDM_OFF_WEIGHT 8'h14
`define MCDM_OFF_FLAGS 8'h18
`define MCDM_OFF_MASK 8'h1c
`define MCDM_OFF_CTRLA 8'h20
`define MCDM_OFF_CTRLB 8'h24
`define MCDM_OFF_PRESC 8'h28
`define MCDM_OFF_PHASE 8'h2c
// ----------------------------------------
// Control register a fields
// ----------------------------------------
`define MCDM_CA_OE 0
`define MCDM_CA_AUTO 1
`define MCDM_CA_CSEL 2
`define MCDM_CA_RST 3
`define MCDM_CA_DIRECT 4
// ----------------------------------------
// Flag and mask fields
// ----------------------------------------
`define MCDM_F_COMM 0
`define MCDM_F_RINC 1
`define MCDM_F_RDEC 2
`define MCDM_F_OI 3
// ----------------------------------------
// Reset values and thresholds
// ----------------------------------------
`define MCDM_RST_8 8'h00
`define MCDM_RST_4 4'h0
`define MCDM_TIMER_MAX 8'hff
`define MCDM_TIMER_LOW 8'h55
`define MCDM_RATIO_MAX 4'hf
`define MCDM_RATIO_MIN 4'h0
`define MCDM_MUL_SHIFT 5
`endif

// *** sim/mcdm_delay_manager_assertions.sv ***
// Checker of bus and event relations of the delay manager
`timescale 1ns/1ps
`include "mcdm_map.vh"
module mcdm_delay_checker (
	// Clock and reset
	input wire clk_sys,
	input wire rst,
	// Bus
	input wire hsel,
	input wire [31:0] haddr,
	input wire [1:0] htrans,
	input wire hwrite,
	input wire [31:0] hwdata,
	input wire hready,
	input wire hreadyout,
	input wire hresp,
	input wire [31:0] hrdata,
	// Events
	input wire commutation_pulse,
	input wire demag_match_pulse,
	input wire event_irq
);
	reg wr_ph_r;
	reg [7:0] ph_addr_r;
	reg [3:0] mask_r;
	reg run_r;
	reg fresh_r;
	// ----------------------------------------
	// Shadow of mask and run state
	// ----------------------------------------
	always @(posedge clk_sys) begin
		if (rst) begin
			wr_ph_r <= 1'b0;
			mask_r <= 4'h0;
			run_r <= 1'b0;
			fresh_r <= 1'b1;
		end else begin
			wr_ph_r <= hsel && hready && htrans[1] && hwrite;
			ph_addr_r <= haddr[7:0];
			if (wr_ph_r)
				fresh_r <= 1'b0;
			if (wr_ph_r && ph_addr_r == `MCDM_OFF_MASK)
				mask_r <= hwdata[3:0];
			if (wr_ph_r && ph_addr_r == `MCDM_OFF_CTRLA)
				run_r <= hwdata[`MCDM_CA_OE] & ~hwdata[`MCDM_CA_RST];
		end
	end
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	sequence s_take_rd;
		hsel && hready && htrans[1] && !hwrite && haddr[31:8] == 24'h0;
	endsequence
	sequence s_stopped;
		!run_r ##1 !run_r;
	endsequence
	AST_BUS_OKAY: assert property (hreadyout && !hresp)
		else $error("bus answer not zero-wait okay");
	AST_RESET_QUIET: assert property ($fell(rst) |-> !event_irq && !commutation_pulse)
		else $error("outputs not cleared by reset");
	AST_FRESH_ZERO: assert property (
		fresh_r && !wr_ph_r && haddr[7:0] <= `MCDM_OFF_DEMAG ##0 s_take_rd |=> hrdata == 32'h0)
		else $error("timer register not zero after reset");
	AST_UNMAPPED_ZERO: assert property (
		haddr[7:0] > `MCDM_OFF_PHASE ##0 s_take_rd |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	AST_MASKED_QUIET: assert property (mask_r == 4'h0 |-> !event_irq)
		else $error("interrupt with all masks clear");
	AST_COMM_IRQ: assert property (commutation_pulse && mask_r[`MCDM_F_COMM] |-> event_irq)
		else $error("commutation without interrupt");
	AST_STOP_NO_COMM: assert property (s_stopped |-> !commutation_pulse)
		else $error("commutation while stopped");
	AST_STOP_NO_DEMAG: assert property (s_stopped |-> !demag_match_pulse)
		else $error("demag pulse while stopped");
endmodule
bind mcdm_delay_manager mcdm_delay_checker chk_u (
	.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
	.hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
	.hresp(hresp), .hrdata(hrdata), .commutation_pulse(commutation_pulse),
	.demag_match_pulse(demag_match_pulse), .event_irq(event_irq)
);

// *** sim/mcdm_rotor_model.sv ***
// Rotor position event detector model
`timescale 1ns/1ps
module mcdm_rotor_model (
	// Clock
	input wire clk_sys,
	// Event pins
	output reg zero_cross_evt,
	output reg demag_evt
);
	initial begin
		zero_cross_evt = 1'b0;
		demag_evt = 1'b0;
	end
	task automatic pulse(input zc);
		@(posedge clk_sys);
		if (zc) begin
			zero_cross_evt <= 1'b1;
		end else begin
			demag_evt <= 1'b1;
		end
		repeat (3) @(posedge clk_sys);
		zero_cross_evt <= 1'b0;
		demag_evt <= 1'b0;
		repeat (3) @(posedge clk_sys);
	endtask
endmodule

// *** sim/mcdm_delay_manager_test.sv ***
// Self-checking bench of the commutation delay manager
`timescale 1ns/1ps
`include "mcdm_map.vh"
module mcdm_delay_manager_test;
	reg clk_sys, rst, hsel, hwrite;
	reg [31:0] haddr, hwdata, rd;
	reg [1:0] htrans;
	wire hreadyout, hresp, zero_cross_evt, demag_evt;
	wire commutation_pulse, demag_match_pulse, event_irq;
	wire [31:0] hrdata;
	wire [3:0] active_ctrl_b;
	wire [7:0] active_phase;
	wire [3:0] sig = {demag_match_pulse, event_irq, commutation_pulse, hreadyout};
	integer mismatches, check_count, i;
	mcdm_delay_manager dut_u (
		.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.zero_cross_evt(zero_cross_evt), .demag_evt(demag_evt),
		.commutation_pulse(commutation_pulse), .demag_match_pulse(demag_match_pulse),
		.active_ctrl_b(active_ctrl_b), .active_phase(active_phase), .event_irq(event_irq)
	);
	mcdm_rotor_model rot_u (.clk_sys(clk_sys), .zero_cross_evt(zero_cross_evt),
		.demag_evt(demag_evt));
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check(input string what, input [31:0] seen, input [31:0] exp);
		check_count = check_count + 1;
		if (seen !== exp) begin
			mismatches = mismatches + 1;
			$display("wrong value %0s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wait_for(input integer k, input integer lim);
		integer n;
		for (n = 0; n < lim; n = n + 1) begin
			@(posedge clk_sys);
			if (sig[k] === 1'b1)
				return;
		end
		mismatches = mismatches + 1;
		wrap_up;
	endtask
	task automatic xfer(input w, input [7:0] a, input [31:0] d);
		@(posedge clk_sys);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		wait_for(0, 20);
		htrans <= 2'b00;
		hwdata <= d;
		wait_for(0, 20);
		rd = hrdata;
	endtask
	task automatic wr(input [7:0] a, input [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rdc(input string what, input [7:0] a, input [31:0] exp);
		xfer(1'b0, a, 32'h0);
		check(what, rd, exp);
	endtask
	task automatic do_reset;
		rst <= 1'b1;
		repeat (20) @(posedge clk_sys);
		rst <= 1'b0;
	endtask
	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end
	initial begin
		rst = 1'b1;
		hsel = 1'b0;
		hwrite = 1'b0;
		haddr = 32'h0;
		hwdata = 32'h0;
		htrans = 2'b00;
		rd = 32'h0;
		mismatches = 0;
		check_count = 0;
		do_reset;
		for (i = 0; i < 5; i = i + 1)
			rdc("timer_reg", i * 4, 32'h0);
		rdc("unmapped", 8'h40, 32'h0);
		wr(8'h40, 32'h5);
		wr(`MCDM_OFF_PRESC, 32'h3);
		rdc("ratio_cfg", `MCDM_OFF_PRESC, 32'h3);
		wr(`MCDM_OFF_PRESC, 32'h0);
		wr(`MCDM_OFF_COMP, 32'h10);
		wr(`MCDM_OFF_CTRLB, 32'ha);
		wr(`MCDM_OFF_PHASE, 32'h5a);
		wr(`MCDM_OFF_MASK, 32'h1);
		check("phase_early", {24'h0, active_phase}, 32'h0);
		wr(`MCDM_OFF_CTRLA, 32'h1);
		wr(`MCDM_OFF_PRESC, 32'h7);
		rdc("ratio_locked", `MCDM_OFF_PRESC, 32'h0);
		wait_for(1, 200);
		check("comm_irq", {31'h0, event_irq}, 32'h1);
		check("ctrlb_act", {28'h0, active_ctrl_b}, 32'ha);
		check("phase_act", {24'h0, active_phase}, 32'h5a);
		xfer(1'b0, `MCDM_OFF_TIMER, 32'h0);
		check("timer_wrap", {31'h0, rd[7:0] <= 8'h10}, 32'h1);
		rot_u.pulse(1'b0);
		wait_for(3, 50);
		rot_u.pulse(1'b1);
		rdc("zc_switched", `MCDM_OFF_ZLAST, 32'h0);
		wait_for(1, 200);
		wr(`MCDM_OFF_FLAGS, 32'h6);
		wait_for(1, 200);
		rdc("ratio_up", `MCDM_OFF_PRESC, 32'h1);
		xfer(1'b0, `MCDM_OFF_FLAGS, 32'h0);
		check("flags_up", rd & 32'h6, 32'h4);
		rdc("comp_shift", `MCDM_OFF_COMP, 32'h08);
		wait_for(1, 200);
		rdc("ratio_down", `MCDM_OFF_PRESC, 32'h0);
		xfer(1'b0, `MCDM_OFF_FLAGS, 32'h0);
		check("flags_down", rd & 32'h4, 32'h0);
		do_reset;
		wr(`MCDM_OFF_ZPREV, 32'h40);
		wr(`MCDM_OFF_ZLAST, 32'h80);
		wr(`MCDM_OFF_WEIGHT, 32'h40);
		wr(`MCDM_OFF_MASK, 32'h2);
		wr(`MCDM_OFF_CTRLA, 32'h3);
		rdc("comp_mul", `MCDM_OFF_COMP, 32'h80);
		wr(`MCDM_OFF_COMP, 32'h11);
		rdc("comp_ro", `MCDM_OFF_COMP, 32'h80);
		rot_u.pulse(1'b1);
		rdc("prev_cap", `MCDM_OFF_ZPREV, 32'h80);
		rdc("comp_ovf", `MCDM_OFF_COMP, 32'hff);
		xfer(1'b0, `MCDM_OFF_FLAGS, 32'h0);
		check("flags_ovf", rd & 32'hc, 32'h8);
		rdc("ratio_min", `MCDM_OFF_PRESC, 32'h0);
		wait_for(2, 600);
		rdc("ratio_auto_up", `MCDM_OFF_PRESC, 32'h1);
		rot_u.pulse(1'b1);
		rot_u.pulse(1'b1);
		rdc("ratio_auto_dn", `MCDM_OFF_PRESC, 32'h0);
		xfer(1'b0, `MCDM_OFF_FLAGS, 32'h0);
		check("flags_dn", rd & 32'h4, 32'h4);
		wr(`MCDM_OFF_CTRLA, 32'h0);
		wr(`MCDM_OFF_FLAGS, 32'h0);
		wr(`MCDM_OFF_TIMER, 32'hff);
		wr(`MCDM_OFF_PRESC, 32'hf);
		wr(`MCDM_OFF_CTRLA, 32'h3);
		rdc("timer_seed", `MCDM_OFF_TIMER, 32'hff);
		repeat (32800) @(posedge clk_sys);
		rdc("ratio_top", `MCDM_OFF_PRESC, 32'h1f);
		rdc("timer_frozen", `MCDM_OFF_TIMER, 32'hff);
		xfer(1'b0, `MCDM_OFF_FLAGS, 32'h0);
		check("flags_top", rd & 32'h2, 32'h0);
		wrap_up;
	end
endmodule
